// >>> include/pio_pkg.sv
// pio_pkg: register indices, bit masks and reset values of the parallel port block.
// assumes an APB slave with 32-bit data; byte address of a register is four times its index.
package pio_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PE_W = 5;
  localparam int unsigned CONV_CH_W = 5;

  // register indices, byte address = index * 4
  localparam logic [5:0] IDX_PORTA_DATA = 6'h00;
  localparam logic [5:0] IDX_PORTA_DIR = 6'h04;
  localparam logic [5:0] IDX_PORTC_DIR = 6'h06;
  localparam logic [5:0] IDX_PORTD_DIR = 6'h07;
  localparam logic [5:0] IDX_PORTE_DATA = 6'h08;
  localparam logic [5:0] IDX_PORTE_DIR = 6'h0C;
  localparam logic [5:0] IDX_PORTA_PUE = 6'h0D;
  localparam logic [5:0] IDX_PORTC_PUE = 6'h0E;
  localparam logic [5:0] IDX_PORTD_PUE = 6'h0F;

  // implemented bits of each register
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_PORTC = 8'h7F;
  localparam logic [7:0] MASK_PORTE = 8'h1F;

  // reset values
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_PUE = 8'h00;
  localparam logic [7:0] RST_PIN = 8'h00;

  // port E pins taken over by on-chip modules
  localparam int unsigned PE_SCI_TX = 0;
  localparam int unsigned PE_SCI_RX = 1;
  localparam int unsigned PE_OSC2 = 3;
  localparam int unsigned PE_OSC1 = 4;

endpackage : pio_pkg

// >>> design/pio_apb_slave.sv
// pio_apb_slave: APB access-phase timing for the port registers.
// assumes psel, penable and address are held by the master until pready.
`timescale 1ns/1ps
module pio_apb_slave
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  output logic pready,
  output logic acc_capture,
  output logic acc_done
);

  logic pready_ff;

  // one wait state: read data is captured first, then shown with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
    end
    else if (pce)
    begin
      pready_ff <= psel & penable & ~pready_ff;
    end
  end

  assign pready = pready_ff;
  assign acc_capture = pce & psel & penable & ~pready_ff;
  assign acc_done = pce & psel & penable & pready_ff;

  a_ready_after_wait: assert property (@(posedge pclk) disable iff (!presetn)
    acc_capture |=> (pready || !pce))
    else $error("pready did not follow the wait state");

endmodule : pio_apb_slave

// >>> design/pio_pin_ctl.sv
// pio_pin_ctl: per-pin buffer, pull-up and read-back logic for one port.
// assumes own marks pins forced to input by a sharing module.
`timescale 1ns/1ps
module pio_pin_ctl
#(
  parameter int unsigned W = 8
)
(
  input wire logic [W-1:0] data,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] pue,
  input wire logic [W-1:0] own,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] pull_on,
  output logic [W-1:0] rd_val
);

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_pin
      assign pin_out[gi] = data[gi];
      // a sharing module wins over the direction bit
      assign pin_oe[gi] = dir[gi] & ~own[gi];
      // pull-up only on an input; output mode kills it whatever pue holds
      assign pull_on[gi] = pue[gi] & ~dir[gi];
      // read back the latch on outputs, the pin on inputs
      assign rd_val[gi] = dir[gi] ? data[gi] : pin_in[gi];
    end
  endgenerate

endmodule : pio_pin_ctl

// >>> design/pio_port_regs.sv
// pio_port_regs: data, direction and pull-up registers of the parallel ports with pin control.
// assumes an APB master on pclk, synchronous pin inputs and sharing-module enables as levels.
//
// Behaviour
// - port C direction, bit 7 zero, reset clear
// - port D direction eight bits, reset clear
// - port E data five bits, reset keeps
// - port E direction five bits, reset clear
// - port A pull-up enable, reset clear
// - port C pull-up enable seven bits
// - port D pull-up enable, reset clear
// - keypad enables make port A inputs
// - module enables take over their pins
// - port A data latches survive reset
// - direction one enables the output buffer
// - reset makes all port A inputs
// - port A pull-up only on inputs
// - data read gives latch or pin
// - data writes always update the latch
// - output mode disables the pull-up
`timescale 1ns/1ps
module pio_port_regs
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] porta_pin_in,
  output logic [7:0] porta_pin_out,
  output logic [7:0] porta_pin_oe,
  output logic [7:0] porta_pullup,
  input wire logic [7:0] keypad_irq_enables,
  output logic [7:0] keypad_inputs,
  input wire logic [pio_pkg::CONV_CH_W-1:0] converter_channel_select,
  output logic [7:0] portb_analog_sel,
  output logic [7:0] portc_pin_oe,
  output logic [7:0] portc_pullup,
  input wire logic serial_periph_enable,
  input wire logic [1:0] timer_one_ch0_edge_level_select,
  input wire logic [1:0] timer_one_ch1_edge_level_select,
  input wire logic [1:0] timer_two_ch0_edge_level_select,
  input wire logic [1:0] timer_two_ch1_edge_level_select,
  output logic [7:0] portd_pin_oe,
  output logic [7:0] portd_pullup,
  output logic [7:0] portd_periph_own,
  input wire logic [pio_pkg::PE_W-1:0] porte_pin_in,
  output logic [pio_pkg::PE_W-1:0] porte_pin_out,
  output logic [pio_pkg::PE_W-1:0] porte_pin_oe,
  output logic [pio_pkg::PE_W-1:0] porte_periph_own,
  input wire logic async_serial_enable,
  input wire logic ext_clock_gen_on,
  input wire logic crystal_amp_enable
);

  function automatic logic reg_hit(input logic [pio_pkg::ADDR_W-1:0] a, input logic [5:0] idx);
    reg_hit = (a[pio_pkg::ADDR_W-1:2] == idx);
  endfunction : reg_hit

  function automatic logic [7:0] conv_onehot(input logic [pio_pkg::CONV_CH_W-1:0] ch);
    logic [7:0] v;
    v = 8'h00;
    if (ch[4:3] == 2'h0)
    begin
      v[ch[2:0]] = 1'b1;
    end
    conv_onehot = v;
  endfunction : conv_onehot

  logic acc_capture;
  logic acc_done;
  logic wr_en;
  logic [7:0] wdat;
  logic [7:0] porta_data_ff;
  logic [7:0] porte_data_ff;
  logic [7:0] porta_dir_ff;
  logic [7:0] portc_dir_ff;
  logic [7:0] portd_dir_ff;
  logic [7:0] porte_dir_ff;
  logic [7:0] porta_pue_ff;
  logic [7:0] portc_pue_ff;
  logic [7:0] portd_pue_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;
  logic [7:0] pa_own;
  logic [7:0] pd_own;
  logic [pio_pkg::PE_W-1:0] pe_own;
  logic [7:0] pa_out;
  logic [7:0] pa_oe;
  logic [7:0] pa_pull;
  logic [7:0] pa_rd;
  logic [7:0] pc_oe;
  logic [7:0] pc_pull;
  logic [7:0] pd_oe;
  logic [7:0] pd_pull;
  logic [pio_pkg::PE_W-1:0] pe_out;
  logic [pio_pkg::PE_W-1:0] pe_oe;
  logic [pio_pkg::PE_W-1:0] pe_rd;
  logic [7:0] porta_pin_out_ff;
  logic [7:0] porta_pin_oe_ff;
  logic [7:0] porta_pullup_ff;
  logic [7:0] keypad_inputs_ff;
  logic [7:0] portb_analog_sel_ff;
  logic [7:0] portc_pin_oe_ff;
  logic [7:0] portc_pullup_ff;
  logic [7:0] portd_pin_oe_ff;
  logic [7:0] portd_pullup_ff;
  logic [7:0] portd_periph_own_ff;
  logic [pio_pkg::PE_W-1:0] porte_pin_out_ff;
  logic [pio_pkg::PE_W-1:0] porte_pin_oe_ff;
  logic [pio_pkg::PE_W-1:0] porte_periph_own_ff;

  pio_apb_slave u_apb
  (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .acc_capture(acc_capture),
    .acc_done(acc_done)
  );

  assign wr_en = acc_done & pwrite;
  assign wdat = pwdata[7:0];

  // pin takeover by the sharing modules
  assign pa_own = keypad_irq_enables;
  always_comb
  begin
    pd_own = 8'h00;
    pd_own[3:0] = {4{serial_periph_enable}};
    pd_own[4] = |timer_one_ch0_edge_level_select;
    pd_own[5] = |timer_one_ch1_edge_level_select;
    pd_own[6] = |timer_two_ch0_edge_level_select;
    pd_own[7] = |timer_two_ch1_edge_level_select;
    pe_own = '0;
    pe_own[pio_pkg::PE_SCI_TX] = async_serial_enable;
    pe_own[pio_pkg::PE_SCI_RX] = async_serial_enable;
    pe_own[pio_pkg::PE_OSC2] = ext_clock_gen_on & crystal_amp_enable;
    pe_own[pio_pkg::PE_OSC1] = ext_clock_gen_on;
  end

  // data latches carry no reset term at all, so reset leaves them as they were
  always_ff @(posedge pclk)
  begin
    if (pce && wr_en && reg_hit(paddr, pio_pkg::IDX_PORTA_DATA))
    begin
      porta_data_ff <= wdat;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (pce && wr_en && reg_hit(paddr, pio_pkg::IDX_PORTE_DATA))
    begin
      porte_data_ff <= wdat & pio_pkg::MASK_PORTE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      porta_dir_ff <= pio_pkg::RST_DIR;
      portc_dir_ff <= pio_pkg::RST_DIR;
      portd_dir_ff <= pio_pkg::RST_DIR;
      porte_dir_ff <= pio_pkg::RST_DIR;
    end
    else if (pce && wr_en)
    begin
      if (reg_hit(paddr, pio_pkg::IDX_PORTA_DIR))
      begin
        porta_dir_ff <= wdat;
      end
      else if (reg_hit(paddr, pio_pkg::IDX_PORTC_DIR))
      begin
        portc_dir_ff <= wdat & pio_pkg::MASK_PORTC;
      end
      else if (reg_hit(paddr, pio_pkg::IDX_PORTD_DIR))
      begin
        portd_dir_ff <= wdat;
      end
      else if (reg_hit(paddr, pio_pkg::IDX_PORTE_DIR))
      begin
        porte_dir_ff <= wdat & pio_pkg::MASK_PORTE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      porta_pue_ff <= pio_pkg::RST_PUE;
      portc_pue_ff <= pio_pkg::RST_PUE;
      portd_pue_ff <= pio_pkg::RST_PUE;
    end
    else if (pce && wr_en)
    begin
      if (reg_hit(paddr, pio_pkg::IDX_PORTA_PUE))
      begin
        porta_pue_ff <= wdat;
      end
      else if (reg_hit(paddr, pio_pkg::IDX_PORTC_PUE))
      begin
        portc_pue_ff <= wdat & pio_pkg::MASK_PORTC;
      end
      else if (reg_hit(paddr, pio_pkg::IDX_PORTD_PUE))
      begin
        portd_pue_ff <= wdat;
      end
    end
  end

  pio_pin_ctl #(.W(8)) u_pa
  (
    .data(porta_data_ff),
    .dir(porta_dir_ff),
    .pue(porta_pue_ff),
    .own(pa_own),
    .pin_in(porta_pin_in),
    .pin_out(pa_out),
    .pin_oe(pa_oe),
    .pull_on(pa_pull),
    .rd_val(pa_rd)
  );

  pio_pin_ctl #(.W(8)) u_pc
  (
    .data(8'h00),
    .dir(portc_dir_ff),
    .pue(portc_pue_ff),
    .own(8'h00),
    .pin_in(8'h00),
    .pin_out(),
    .pin_oe(pc_oe),
    .pull_on(pc_pull),
    .rd_val()
  );

  pio_pin_ctl #(.W(8)) u_pd
  (
    .data(8'h00),
    .dir(portd_dir_ff),
    .pue(portd_pue_ff),
    .own(pd_own),
    .pin_in(8'h00),
    .pin_out(),
    .pin_oe(pd_oe),
    .pull_on(pd_pull),
    .rd_val()
  );

  pio_pin_ctl #(.W(pio_pkg::PE_W)) u_pe
  (
    .data(porte_data_ff[pio_pkg::PE_W-1:0]),
    .dir(porte_dir_ff[pio_pkg::PE_W-1:0]),
    .pue('0),
    .own(pe_own),
    .pin_in(porte_pin_in),
    .pin_out(pe_out),
    .pin_oe(pe_oe),
    .pull_on(),
    .rd_val(pe_rd)
  );

  // read mux; unmapped addresses answer zero with pslverr
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (reg_hit(paddr, pio_pkg::IDX_PORTA_DATA))
    begin
      nxt_prdata[7:0] = pa_rd;
    end
    else if (reg_hit(paddr, pio_pkg::IDX_PORTA_DIR))
    begin
      nxt_prdata[7:0] = porta_dir_ff;
    end
    else if (reg_hit(paddr, pio_pkg::IDX_PORTC_DIR))
    begin
      nxt_prdata[7:0] = portc_dir_ff;
    end
    else if (reg_hit(paddr, pio_pkg::IDX_PORTD_DIR))
    begin
      nxt_prdata[7:0] = portd_dir_ff;
    end
    else if (reg_hit(paddr, pio_pkg::IDX_PORTE_DATA))
    begin
      nxt_prdata[pio_pkg::PE_W-1:0] = pe_rd;
    end
    else if (reg_hit(paddr, pio_pkg::IDX_PORTE_DIR))
    begin
      nxt_prdata[7:0] = porte_dir_ff;
    end
    else if (reg_hit(paddr, pio_pkg::IDX_PORTA_PUE))
    begin
      nxt_prdata[7:0] = porta_pue_ff;
    end
    else if (reg_hit(paddr, pio_pkg::IDX_PORTC_PUE))
    begin
      nxt_prdata[7:0] = portc_pue_ff;
    end
    else if (reg_hit(paddr, pio_pkg::IDX_PORTD_PUE))
    begin
      nxt_prdata[7:0] = portd_pue_ff;
    end
    else
    begin
      nxt_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (pce)
    begin
      if (acc_capture)
      begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end
      else if (acc_done)
      begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // registered pad drive: pins follow register writes one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      porta_pin_out_ff <= pio_pkg::RST_PIN;
      porta_pin_oe_ff <= pio_pkg::RST_PIN;
      porta_pullup_ff <= pio_pkg::RST_PIN;
      keypad_inputs_ff <= pio_pkg::RST_PIN;
    end
    else if (pce)
    begin
      porta_pin_out_ff <= pa_out;
      porta_pin_oe_ff <= pa_oe;
      porta_pullup_ff <= pa_pull;
      keypad_inputs_ff <= porta_pin_in & keypad_irq_enables;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      portb_analog_sel_ff <= pio_pkg::RST_PIN;
      portc_pin_oe_ff <= pio_pkg::RST_PIN;
      portc_pullup_ff <= pio_pkg::RST_PIN;
      portd_pin_oe_ff <= pio_pkg::RST_PIN;
      portd_pullup_ff <= pio_pkg::RST_PIN;
      portd_periph_own_ff <= pio_pkg::RST_PIN;
    end
    else if (pce)
    begin
      portb_analog_sel_ff <= conv_onehot(converter_channel_select);
      portc_pin_oe_ff <= pc_oe;
      portc_pullup_ff <= pc_pull;
      portd_pin_oe_ff <= pd_oe;
      portd_pullup_ff <= pd_pull;
      portd_periph_own_ff <= pd_own;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      porte_pin_out_ff <= '0;
      porte_pin_oe_ff <= '0;
      porte_periph_own_ff <= '0;
    end
    else if (pce)
    begin
      porte_pin_out_ff <= pe_out;
      porte_pin_oe_ff <= pe_oe;
      porte_periph_own_ff <= pe_own;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign porta_pin_out = porta_pin_out_ff;
  assign porta_pin_oe = porta_pin_oe_ff;
  assign porta_pullup = porta_pullup_ff;
  assign keypad_inputs = keypad_inputs_ff;
  assign portb_analog_sel = portb_analog_sel_ff;
  assign portc_pin_oe = portc_pin_oe_ff;
  assign portc_pullup = portc_pullup_ff;
  assign portd_pin_oe = portd_pin_oe_ff;
  assign portd_pullup = portd_pullup_ff;
  assign portd_periph_own = portd_periph_own_ff;
  assign porte_pin_out = porte_pin_out_ff;
  assign porte_pin_oe = porte_pin_oe_ff;
  assign porte_periph_own = porte_periph_own_ff;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr(logic [5:0] idx);
    wr_en && reg_hit(paddr, idx);
  endsequence

  sequence s_rd_capture(logic [5:0] idx);
    acc_capture && !pwrite && reg_hit(paddr, idx);
  endsequence

  a_dirc_top_zero: assert property (portc_dir_ff[7] == 1'b0 && portc_pue_ff[7] == 1'b0)
    else $error("port C bit 7 not zero");

  a_porte_top_zero: assert property (porte_dir_ff[7:5] == 3'h0)
    else $error("port E direction upper bits not zero");

  a_reset_inputs: assert property ($rose(presetn) |-> porta_dir_ff == 8'h00
    && portd_dir_ff == 8'h00 && porta_pue_ff == 8'h00 && portd_pue_ff == 8'h00)
    else $error("direction or pull-up not clear after reset");

  a_dird_write: assert property (s_wr(pio_pkg::IDX_PORTD_DIR) |=>
    portd_dir_ff == $past(pwdata[7:0]))
    else $error("port D direction write lost");

  a_latch_write: assert property (s_wr(pio_pkg::IDX_PORTA_DATA) |=>
    porta_data_ff == $past(pwdata[7:0]))
    else $error("port A latch not written");

  a_porte_latch: assert property (s_wr(pio_pkg::IDX_PORTE_DATA) |=>
    porte_data_ff == ($past(pwdata[7:0]) & 8'h1F))
    else $error("port E latch write wrong");

  a_pue_write: assert property (s_wr(pio_pkg::IDX_PORTA_PUE) |=>
    porta_pue_ff == $past(pwdata[7:0]))
    else $error("port A pull-up enable write lost");

  a_oe_from_dir: assert property (pce |=>
    porta_pin_oe == ($past(porta_dir_ff) & ~$past(keypad_irq_enables)))
    else $error("port A buffer enable wrong");

  a_pull_inputs: assert property ((porta_pullup & $past(porta_dir_ff)) == 8'h00)
    else $error("pull-up on an output pin");

  a_read_mix: assert property (s_rd_capture(pio_pkg::IDX_PORTA_DATA) ##1 pce |->
    prdata[7:0] == (($past(porta_dir_ff) & $past(porta_data_ff))
    | (~$past(porta_dir_ff) & $past(porta_pin_in))) && pready)
    else $error("port A read mix wrong");

  a_unmapped_zero: assert property (acc_done && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule : pio_port_regs

// >>> test/pio_pin_model.sv
// pio_pin_model: outside world of ports A and E, resolving each pin level.
// assumes the bench supplies the level that outside devices drive onto undriven pins.
`timescale 1ns/1ps
module pio_pin_model
(
  input wire logic [7:0] ext_a,
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] a_pull,
  output logic [7:0] a_pin,
  input wire logic [4:0] ext_e,
  input wire logic [4:0] e_out,
  input wire logic [4:0] e_oe,
  output logic [4:0] e_pin
);
  // a driven pin wins; a pulled pin reads high, else the outside level shows
  assign a_pin = (a_oe & a_out) | (~a_oe & (a_pull | ext_a));
  assign e_pin = (e_oe & e_out) | (~e_oe & ext_e);
endmodule : pio_pin_model

// >>> test/parallel_io_port_regs_tb_top.sv
// parallel_io_port_regs_tb_top: random register, pin and takeover checks against a bench model.
// assumes pce is high except for three cycles in pass 6; the pin model closes the loop on ports A and E.
`timescale 1ns/1ps
module parallel_io_port_regs_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'hE36B13E2;
  logic [7:0] porta_pin_in, porta_pin_out, porta_pin_oe, porta_pullup, keypad_inputs;
  logic [7:0] keypad_irq_enables = 8'h00, ext_a = 8'h00, portb_analog_sel;
  logic [4:0] converter_channel_select = 5'h00, ext_e = 5'h00;
  logic [7:0] portc_pin_oe, portc_pullup, portd_pin_oe, portd_pullup, portd_periph_own;
  logic serial_periph_enable = 1'b0, async_serial_enable = 1'b0;
  logic ext_clock_gen_on = 1'b0, crystal_amp_enable = 1'b0;
  logic [1:0] timer_one_ch0_edge_level_select = 2'h0, timer_one_ch1_edge_level_select = 2'h0;
  logic [1:0] timer_two_ch0_edge_level_select = 2'h0, timer_two_ch1_edge_level_select = 2'h0;
  logic [4:0] porte_pin_in, porte_pin_out, porte_pin_oe, porte_periph_own;
  int n_mismatch = 0, compares = 0;
  int m [16];
  logic [5:0] ix [9] = '{6'h00, 6'h08, 6'h04, 6'h06, 6'h07, 6'h0C, 6'h0D, 6'h0E, 6'h0F};
  logic [7:0] mk [9] = '{8'hFF, 8'h1F, 8'hFF, 8'h7F, 8'hFF, 8'h1F, 8'hFF, 8'h7F, 8'hFF};

  always #5 pclk = ~pclk;

  pio_port_regs pio_port_regs_i (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .porta_pin_in, .porta_pin_out, .porta_pin_oe,
    .porta_pullup, .keypad_irq_enables, .keypad_inputs, .converter_channel_select,
    .portb_analog_sel, .portc_pin_oe, .portc_pullup, .serial_periph_enable,
    .timer_one_ch0_edge_level_select, .timer_one_ch1_edge_level_select,
    .timer_two_ch0_edge_level_select, .timer_two_ch1_edge_level_select, .portd_pin_oe,
    .portd_pullup, .portd_periph_own, .porte_pin_in, .porte_pin_out, .porte_pin_oe,
    .porte_periph_own, .async_serial_enable, .ext_clock_gen_on, .crystal_amp_enable);

  pio_pin_model pio_pin_model_i (.ext_a(ext_a), .a_out(porta_pin_out), .a_oe(porta_pin_oe),
    .a_pull(porta_pullup), .a_pin(porta_pin_in), .ext_e(ext_e), .e_out(porte_pin_out),
    .e_oe(porte_pin_oe), .e_pin(porte_pin_in));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected port A pin level as the outside sees it
  function automatic logic [7:0] pa();
    logic [7:0] oe;
    oe = m[4] & ~keypad_irq_enables;
    return (oe & m[0]) | (~oe & ((m[13] & ~m[4]) | ext_a));
  endfunction : pa

  function automatic logic [31:0] exp_rd(input logic [5:0] x);
    case (x)
      6'h00: return (m[4] & m[0]) | (~m[4] & pa());
      6'h08: return ((m[12] & m[8]) | (~m[12] & ext_e)) & 32'h1F;
      default: return m[x];
    endcase
  endfunction : exp_rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_all(input int from);
    logic [31:0] r;
    logic e;
    for (int i = from; i < 9; i++)
    begin
      apb(1'b0, {ix[i], 2'h0}, 32'h0, r, e);
      chk(r, exp_rd(ix[i]));
      chk(e, 32'h0);
    end
  endtask : rd_all

  task automatic chk_pins;
    logic [7:0] od;
    logic [4:0] oe5;
    od = {|timer_two_ch1_edge_level_select, |timer_two_ch0_edge_level_select,
          |timer_one_ch1_edge_level_select, |timer_one_ch0_edge_level_select,
          {4{serial_periph_enable}}};
    oe5 = {ext_clock_gen_on, ext_clock_gen_on & crystal_amp_enable, 1'b0,
           {2{async_serial_enable}}};
    chk(porta_pin_oe, m[4] & ~keypad_irq_enables);
    chk(porta_pullup, m[13] & ~m[4]);
    chk(porta_pin_out, m[0]);
    chk(keypad_inputs, pa() & keypad_irq_enables);
    chk(portb_analog_sel, converter_channel_select < 8 ? 32'h1 << converter_channel_select
        : 32'h0);
    chk(portc_pin_oe, m[6]);
    chk(portc_pullup, m[14] & ~m[6]);
    chk(portd_pin_oe, m[7] & ~od);
    chk(portd_pullup, m[15] & ~m[7]);
    chk(portd_periph_own, od);
    chk(porte_pin_oe, m[12] & ~oe5);
    chk(porte_pin_out, m[8]);
    chk(porte_periph_own, oe5);
  endtask : chk_pins

  initial
  begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    logic [31:0] r, d;
    logic e;
    foreach (m[j]) m[j] = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_all(2);
    for (int k = 0; k < 24; k++)
    begin
      r = rnd();
      ext_a <= r[7:0];
      ext_e <= r[12:8];
      keypad_irq_enables <= r[20:13];
      converter_channel_select <= r[25:21];
      serial_periph_enable <= r[26];
      async_serial_enable <= r[27];
      ext_clock_gen_on <= r[28];
      crystal_amp_enable <= r[29];
      d = rnd();
      timer_one_ch0_edge_level_select <= d[1:0];
      timer_one_ch1_edge_level_select <= d[3:2];
      timer_two_ch0_edge_level_select <= d[5:4];
      timer_two_ch1_edge_level_select <= d[7:6];
      // low address bits vary to show that only the word index decodes
      for (int i = 0; i < 9; i++)
      begin
        d = rnd();
        apb(1'b1, {ix[i], k[1:0]}, d, r, e);
        m[ix[i]] = d & mk[i];
      end
      apb(1'b1, k[0] ? 8'h14 : 8'h40, rnd(), r, e);
      chk(e, 32'h1);
      apb(1'b0, k[0] ? 8'h14 : 8'h40, 32'h0, r, e);
      chk(r, 32'h0);
      chk(e, 32'h1);
      repeat (3) @(posedge pclk);
      chk_pins();
      rd_all(0);
      if (k == 6)
      begin
        // clock enable low: a takeover change must not reach the pad
        pce <= 1'b0;
        keypad_irq_enables <= ~keypad_irq_enables;
        repeat (3) @(posedge pclk);
        chk(porta_pin_oe, m[4] & keypad_irq_enables);
        pce <= 1'b1;
      end
      if (k == 12)
      begin
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ix[i]) if (i > 1) m[ix[i]] = 0;
        repeat (3) @(posedge pclk);
        chk_pins();
        rd_all(0);
      end
    end
    end_sim();
  end
endmodule : parallel_io_port_regs_tb_top
